// ### retention_params.svh
// Constants and behaviour summary for the static retention control pair.
// Behaviour
// - I/Os tristated until last supply active
// - Tristate I/Os when first supply drops
// - Tristate behaviour independent of supply order
// - Core power loss clears held state
// - Second variant waits for core permit
// - Entry ties clocks high, stops PLLs
// - Manager gates clocks cleanly, fully synchronous
// - Manager waits PLL lock before release
// - Externally gated clocks held at one
// - Use active-low top-level set/reset
// - Self reset releases on exit edge
// - Outputs enable up to 200 ns late
// - Release undriven inputs only after entry
// - Latch asynchronous paths before entry
// - Test logic powered but idle
// - Permit low blocks pin, high enables
// - Permit ANDed with request for entry
// - Permit held high during retention
// - Request pin low asserts, high exits
// - PLL clocks stop within 1 us
// - Permit zero prevents or ends retention
`ifndef RETENTION_PARAMS_SVH
`define RETENTION_PARAMS_SVH
// Clock period in picoseconds.
`define REF_CLK_PERIOD_PS 4000
// Latest output enable after input enable on exit, in nanoseconds.
`define OUT_ENABLE_LAG_NS 200
// Output lag in cycles, a longest time so rounded down.
`define OUT_ENABLE_LAG_CYC ((`OUT_ENABLE_LAG_NS * 1000) / `REF_CLK_PERIOD_PS)
// Latest PLL stop after entry decision, in microseconds.
`define PLL_STOP_US 1
// PLL stop in cycles, rounded down.
`define PLL_STOP_CYC ((`PLL_STOP_US * 1000000) / `REF_CLK_PERIOD_PS)
// Default PLL lock allowance in cycles for the manager.
`define PLL_LOCK_CYC 64
// Default persistence check for a request in cycles.
`define REQ_PERSIST_CYC 4
`endif

// ### retention_pkg.sv
// Types shared by the retention device and its manager.
package retention_pkg;
  // Device retention states.
  typedef enum logic [2:0] {
    DEV_OFF = 3'b000,
    DEV_RUN = 3'b001,
    DEV_ENTER = 3'b010,
    DEV_HOLD = 3'b011,
    DEV_EXIT = 3'b100
  } dev_state_t;
  // Manager states.
  typedef enum logic [2:0] {
    MGR_IDLE = 3'b000,
    MGR_CHECK = 3'b001,
    MGR_HOUSE = 3'b010,
    MGR_GATE = 3'b011,
    MGR_PERMIT = 3'b100,
    MGR_FROZEN = 3'b101,
    MGR_LOCK = 3'b110
  } mgr_state_t;
endpackage

// ### retention_if.sv
// Interface joining the retention device and its management logic.
`timescale 1ns/100ps
`default_nettype none
interface retention_if;
  // Freeze request pin, active low, driven by the manager.
  logic freeze_request_pin_n;
  // Core entry permit, active high, driven by the manager.
  logic core_entry_permit;
  // Device reports it is in retention.
  logic retention_active;
  // Device reports internal clock inputs tied high.
  logic clocks_tied_high;
  // Device reports PLLs running and locked.
  logic pll_running;
  // Modport for the documented device.
  modport device (
    input freeze_request_pin_n,
    input core_entry_permit,
    output retention_active,
    output clocks_tied_high,
    output pll_running
  );
  // Modport for the management logic.
  modport manager (
    output freeze_request_pin_n,
    output core_entry_permit,
    input retention_active,
    input clocks_tied_high,
    input pll_running
  );
endinterface
`default_nettype wire

// ### retention_device.sv
// Hard retention control with supply-driven I/O tristate.
`timescale 1ns/100ps
`default_nettype none
`include "retention_params.svh"
module retention_device
  import retention_pkg::*;
#(
  parameter int OUT_LAG_CYC = `OUT_ENABLE_LAG_CYC,
  parameter int PLL_STOP_CYC = `PLL_STOP_CYC,
  parameter int IO_W = 8
)
(
  input wire logic ref_clk,
  input wire logic rst,
  retention_if.device link,
  input wire logic core_supply_ok,
  input wire logic io_supply_ok,
  input wire logic [IO_W-1:0] core_out_data,
  input wire logic [IO_W-1:0] pad_in_data,
  input wire logic second_variant,
  output logic [IO_W-1:0] pad_out_data,
  output logic [IO_W-1:0] pad_out_en,
  output logic [IO_W-1:0] core_in_data,
  output logic state_valid,
  output logic jtag_idle
);
  // Elaboration check: the 16-bit counter serves only counts from 1 to 65535.
  if (OUT_LAG_CYC < 1 || PLL_STOP_CYC < 1 || PLL_STOP_CYC > 65535 || OUT_LAG_CYC > 65535)
  begin
    $error("retention_device: counts out of range.");
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Decision logic.
  // Both supplies up, in any order.
  logic supplies_up;
  // Entry request after permit gating.
  logic enter_req;
  assign supplies_up = core_supply_ok & io_supply_ok;
  // Permit low blocks the pin; the first variant ignores the permit.
  assign enter_req = ~link.freeze_request_pin_n &
    (link.core_entry_permit | ~second_variant);
  ////////////////////////////////////////////////////////////////////////////////
  // State registers.
  dev_state_t state_reg, state_next; // Current state.
  logic [15:0] cnt_reg, cnt_next; // Delay counter.
  logic oe_reg, oe_next; // Pad outputs enabled.
  logic ret_reg, ret_next; // In retention.
  logic tie_reg, tie_next; // Clocks tied high.
  logic pll_reg, pll_next; // PLL running.
  logic valid_reg, valid_next; // Held state still valid.
  logic [IO_W-1:0] out_reg, out_next; // Pad output data.
  logic [IO_W-1:0] in_reg, in_next; // Core-side input data.
  // Next-state computation.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    oe_next = oe_reg;
    ret_next = ret_reg;
    tie_next = tie_reg;
    pll_next = pll_reg;
    valid_next = valid_reg;
    out_next = core_out_data;
    in_next = tie_reg ? {IO_W{1'b1}} : pad_in_data;
    if (!supplies_up)
    begin
      // Any supply down forces tristate; only core supply loss loses held state.
      state_next = DEV_OFF;
      oe_next = 1'b0;
      ret_next = 1'b0;
      tie_next = 1'b0;
      pll_next = 1'b0;
      if (!core_supply_ok)
      begin
        valid_next = 1'b0;
      end
    end
    else
    begin
      case (state_reg)
        DEV_OFF:
        begin
          // Last supply reached: drive the buffer input values.
          state_next = DEV_RUN;
          oe_next = 1'b1;
          pll_next = 1'b1;
          valid_next = 1'b1;
        end
        DEV_RUN:
        begin
          if (enter_req)
          begin
            state_next = DEV_ENTER;
            cnt_next = 16'(PLL_STOP_CYC - 1);
            tie_next = 1'b1;
          end
        end
        DEV_ENTER:
        begin
          // PLLs stop within the bound; abort if request dropped.
          if (!enter_req)
          begin
            state_next = DEV_EXIT;
            // One less, so outputs enable no later than the lag after inputs.
            cnt_next = 16'(OUT_LAG_CYC - 1);
            tie_next = 1'b0;
          end
          else if (cnt_reg == 16'h0000)
          begin
            state_next = DEV_HOLD;
            pll_next = 1'b0;
            oe_next = 1'b0;
            ret_next = 1'b1;
          end
          else
          begin
            cnt_next = cnt_reg - 16'h0001;
          end
        end
        DEV_HOLD:
        begin
          // Pin release or permit drop ends retention.
          if (!enter_req)
          begin
            state_next = DEV_EXIT;
            ret_next = 1'b0;
            tie_next = 1'b0;
            pll_next = 1'b1;
            // The zero count costs an edge, so the lag is loaded one short.
            cnt_next = 16'(OUT_LAG_CYC - 1);
          end
        end
        DEV_EXIT:
        begin
          // Inputs are live now; outputs follow after the lag.
          if (cnt_reg == 16'h0000)
          begin
            state_next = DEV_RUN;
            oe_next = 1'b1;
          end
          else
          begin
            cnt_next = cnt_reg - 16'h0001;
          end
        end
        default:
        begin
          state_next = DEV_OFF;
        end
      endcase
    end
  end
  // Register stage.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= DEV_OFF;
      cnt_reg <= 16'h0000;
      oe_reg <= 1'b0;
      ret_reg <= 1'b0;
      tie_reg <= 1'b0;
      pll_reg <= 1'b0;
      valid_reg <= 1'b0;
      out_reg <= '0;
      in_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      oe_reg <= oe_next;
      ret_reg <= ret_next;
      tie_reg <= tie_next;
      pll_reg <= pll_next;
      valid_reg <= valid_next;
      out_reg <= out_next;
      in_reg <= in_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign pad_out_data = out_reg;
  assign pad_out_en = {IO_W{oe_reg}};
  assign core_in_data = in_reg;
  assign state_valid = valid_reg;
  assign jtag_idle = ret_reg;
  assign link.retention_active = ret_reg;
  assign link.clocks_tied_high = tie_reg;
  assign link.pll_running = pll_reg;
endmodule
`default_nettype wire

// ### retention_manager.sv
// User management logic that gates clocks and grants retention entry.
`timescale 1ns/100ps
`default_nettype none
`include "retention_params.svh"
module retention_manager
  import retention_pkg::*;
#(
  parameter int PERSIST_CYC = `REQ_PERSIST_CYC,
  parameter int LOCK_CYC = `PLL_LOCK_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst,
  retention_if.manager link,
  input wire logic sleep_request_n,
  input wire logic done_housekeeping,
  output logic wait_housekeeping,
  output logic clock_gate_n,
  output logic async_path_hold,
  output logic frozen,
  output logic reset_out_n
);
  // Elaboration check: the 16-bit counter serves only counts from 1 to 65535.
  if (PERSIST_CYC < 1 || LOCK_CYC < 1 || PERSIST_CYC > 65535 || LOCK_CYC > 65535)
  begin
    $error("retention_manager: counts out of range.");
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Request synchroniser; the first stage feeds only the second.
  logic req_meta_reg, req_sync_reg;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      req_meta_reg <= 1'b1;
      req_sync_reg <= 1'b1;
    end
    else
    begin
      req_meta_reg <= sleep_request_n;
      req_sync_reg <= req_meta_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  mgr_state_t state_reg, state_next; // Current state.
  logic [15:0] cnt_reg, cnt_next; // Persistence and lock counter.
  logic pin_reg, pin_next; // Freeze pin level, low asserts.
  logic permit_reg, permit_next; // Entry permit.
  logic wait_reg, wait_next; // Housekeeping request.
  logic gate_reg, gate_next; // Clock gate, low gates.
  logic hold_reg, hold_next; // Async path latch hold.
  logic frz_reg, frz_next; // Frozen flag.
  logic rst_out_reg, rst_out_next; // Registered active-low reset out.
  // Next-state computation.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pin_next = pin_reg;
    permit_next = permit_reg;
    wait_next = wait_reg;
    gate_next = gate_reg;
    hold_next = hold_reg;
    frz_next = frz_reg;
    rst_out_next = 1'b1;
    case (state_reg)
      MGR_IDLE:
      begin
        if (!req_sync_reg)
        begin
          state_next = MGR_CHECK;
          cnt_next = 16'(PERSIST_CYC - 1);
        end
      end
      MGR_CHECK:
      begin
        // Request must persist before housekeeping starts.
        if (req_sync_reg)
        begin
          state_next = MGR_IDLE;
        end
        else if (cnt_reg == 16'h0000)
        begin
          state_next = MGR_HOUSE;
          wait_next = 1'b1;
        end
        else
        begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      MGR_HOUSE:
      begin
        if (done_housekeeping)
        begin
          state_next = MGR_GATE;
          wait_next = 1'b0;
          gate_next = 1'b0;
          hold_next = 1'b1;
        end
      end
      MGR_GATE:
      begin
        // Clocks gated: grant entry and assert the pin.
        state_next = MGR_PERMIT;
        permit_next = 1'b1;
        pin_next = 1'b0;
      end
      MGR_PERMIT:
      begin
        // Undriven inputs released only once device is in.
        if (link.retention_active)
        begin
          state_next = MGR_FROZEN;
          frz_next = 1'b1;
        end
        else if (req_sync_reg)
        begin
          state_next = MGR_LOCK;
          pin_next = 1'b1;
          cnt_next = 16'(LOCK_CYC - 1);
        end
      end
      MGR_FROZEN:
      begin
        // Permit stays high; releasing the pin causes exit.
        if (req_sync_reg)
        begin
          state_next = MGR_LOCK;
          pin_next = 1'b1;
          cnt_next = 16'(LOCK_CYC - 1);
        end
      end
      MGR_LOCK:
      begin
        // Allow full PLL lock time before releasing the gates.
        if (cnt_reg != 16'h0000)
        begin
          cnt_next = cnt_reg - 16'h0001;
        end
        else if (link.pll_running && !link.retention_active)
        begin
          state_next = MGR_IDLE;
          permit_next = 1'b0;
          gate_next = 1'b1;
          hold_next = 1'b0;
          frz_next = 1'b0;
        end
      end
      default:
      begin
        state_next = MGR_IDLE;
      end
    endcase
  end
  // Register stage.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= MGR_IDLE;
      cnt_reg <= 16'h0000;
      pin_reg <= 1'b1;
      permit_reg <= 1'b0;
      wait_reg <= 1'b0;
      gate_reg <= 1'b1;
      hold_reg <= 1'b0;
      frz_reg <= 1'b0;
      rst_out_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pin_reg <= pin_next;
      permit_reg <= permit_next;
      wait_reg <= wait_next;
      gate_reg <= gate_next;
      hold_reg <= hold_next;
      frz_reg <= frz_next;
      rst_out_reg <= rst_out_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign link.freeze_request_pin_n = pin_reg;
  assign link.core_entry_permit = permit_reg;
  assign wait_housekeeping = wait_reg;
  assign clock_gate_n = gate_reg;
  assign async_path_hold = hold_reg;
  assign frozen = frz_reg;
  // Active-low reset out, high while frozen so tie-high is harmless.
  assign reset_out_n = rst_out_reg;
endmodule
`default_nettype wire

// ### retention_checker.sv
// Concurrent checks on the link between the retention device and its manager.
`timescale 1ns/100ps
`default_nettype none
`include "retention_params.svh"
module retention_checker
#(
  parameter int PLL_STOP_CYC = `PLL_STOP_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic freeze_request_pin_n,
  input wire logic core_entry_permit,
  input wire logic retention_active,
  input wire logic clocks_tied_high,
  input wire logic pll_running
);
  // One clock domain; the watched device runs with the permit required.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  no_lone_entry_a: assert property ((freeze_request_pin_n || !core_entry_permit)
    && !retention_active |=> !retention_active)
    else $error("retention entered without request and permit");
  tie_on_entry_a: assert property (!freeze_request_pin_n && core_entry_permit
    && pll_running && !clocks_tied_high |=> clocks_tied_high)
    else $error("clocks not tied after entry request");
  pll_stop_time_a: assert property ($rose(clocks_tied_high) |-> !retention_active
    ##PLL_STOP_CYC (retention_active || freeze_request_pin_n || !core_entry_permit))
    else $error("retention not reached in stop time");
  held_state_a: assert property (retention_active |-> clocks_tied_high && !pll_running)
    else $error("clocks or pll wrong while retained");
  pin_exit_a: assert property (retention_active && freeze_request_pin_n |=> !retention_active)
    else $error("no exit on released request");
  exit_resume_a: assert property ($fell(retention_active) |-> pll_running
    && !clocks_tied_high)
    else $error("clocks not resumed on exit");
  permit_hold_a: assert property (retention_active && !freeze_request_pin_n
    |-> core_entry_permit)
    else $error("permit dropped while retained");
  lock_wait_a: assert property ($fell(core_entry_permit) |-> pll_running
    && !retention_active && freeze_request_pin_n)
    else $error("permit withdrawn before pll back");
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the retention device and manager pair.
`timescale 1ns/100ps
`default_nettype none
module tb
  import retention_pkg::*;
;
  localparam int LAG = 2; // Shortened output lag.
  localparam int STOP = 2; // Shortened PLL stop count.
  logic ref_clk = 1'b0; // Reference clock.
  logic rst = 1'b1; // Synchronous reset.
  logic sup_core = 1'b1; // Core supply of the second device.
  logic sup_io = 1'b1; // I/O supply of the second device.
  logic variant_b = 1'b1; // Variant select of the second device.
  logic sleep_n = 1'b1; // Sleep request into the manager.
  logic done_hk = 1'b0; // Housekeeping done.
  logic [7:0] pin_d = 8'h00; // Pad input data.
  logic [7:0] cout_d = 8'h00; // Core output data.
  logic [7:0] pout_a, oe_a, cin_a, pout_b, oe_b, cin_b; // Pad side results.
  logic sv_a, jt_a, sv_b, jt_b, wait_hk, gate_n, hold, frozen, rst_out_n; // Flags.
  int n_fail = 0; // Mismatches.
  int n_compared = 0; // Comparisons.
  int seed = 99; // Random seed.
  int n; // Wait counter.
  int lag; // Output lag counter.
  retention_if link_a ();
  retention_if link_b ();
  // Free-running clock.
  always #2 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  retention_device #(.OUT_LAG_CYC(LAG), .PLL_STOP_CYC(STOP)) retention_device_i (
    .ref_clk(ref_clk), .rst(rst), .link(link_a), .core_supply_ok(1'b1),
    .io_supply_ok(1'b1), .core_out_data(cout_d), .pad_in_data(pin_d),
    .second_variant(1'b1), .pad_out_data(pout_a), .pad_out_en(oe_a),
    .core_in_data(cin_a), .state_valid(sv_a), .jtag_idle(jt_a));
  // Second device is driven by the bench to break the manager's rules.
  retention_device #(.OUT_LAG_CYC(LAG), .PLL_STOP_CYC(STOP)) retention_device_b_i (
    .ref_clk(ref_clk), .rst(rst), .link(link_b), .core_supply_ok(sup_core),
    .io_supply_ok(sup_io), .core_out_data(cout_d), .pad_in_data(pin_d),
    .second_variant(variant_b), .pad_out_data(pout_b), .pad_out_en(oe_b),
    .core_in_data(cin_b), .state_valid(sv_b), .jtag_idle(jt_b));
  retention_manager #(.PERSIST_CYC(2), .LOCK_CYC(2)) retention_manager_i (
    .ref_clk(ref_clk), .rst(rst), .link(link_a), .sleep_request_n(sleep_n),
    .done_housekeeping(done_hk), .wait_housekeeping(wait_hk), .clock_gate_n(gate_n),
    .async_path_hold(hold), .frozen(frozen), .reset_out_n(rst_out_n));
  retention_checker #(.PLL_STOP_CYC(STOP)) retention_checker_i (
    .ref_clk(ref_clk), .rst(rst), .freeze_request_pin_n(link_a.freeze_request_pin_n),
    .core_entry_permit(link_a.core_entry_permit),
    .retention_active(link_a.retention_active),
    .clocks_tied_high(link_a.clocks_tied_high), .pll_running(link_a.pll_running));
  ////////////////////////////////////////////////////////////////////////////////
  // Advance k edges, then settle past the edge.
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // Compares one result and reports a mismatch.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Entry decision of the device model.
  function automatic logic enter_req(input logic pin_n, input logic permit, input logic v2);
    return !pin_n && (permit || !v2);
  endfunction
  // Picks a watched handshake flag.
  function automatic logic sig(input int k);
    case (k)
      0: return wait_hk;
      1: return frozen;
      default: return link_a.retention_active;
    endcase
  endfunction
  // Bounded wait for a flag, then checks it.
  task automatic wait_on(input int k, input logic v);
    n = 0;
    while (sig(k) !== v && n < 60)
    begin
      step(1);
      n++;
    end
    chk(8'(sig(k)), 8'(v), "handshake");
  endtask
  // Passes random data through the first device.
  task automatic data_chk(input logic tied);
    pin_d = 8'($random(seed));
    cout_d = 8'($random(seed));
    step(1);
    chk(cin_a, tied ? 8'hff : pin_d, "core input");
    chk(pout_a, cout_d, "pad output");
  endtask
  // Drives the bench side of the second link.
  task automatic drive_b(input logic pin_n, input logic permit);
    link_b.freeze_request_pin_n = pin_n;
    link_b.core_entry_permit = permit;
  endtask
  // Prints the counts and the verdict.
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    drive_b(1'b1, 1'b0);
    step(8);
    rst = 1'b0;
    step(3);
    chk(oe_a, 8'hff, "power-up enable");
    chk(8'({sv_a, link_a.pll_running}), 8'h03, "running");
    repeat (4) data_chk(1'b0);
    $display("test 1 done");
    // A request shorter than the persistence window is dropped.
    sleep_n = 1'b0;
    step(2);
    sleep_n = 1'b1;
    step(5);
    chk(8'(wait_hk), 8'h00, "short request");
    // Full sleep cycle through the manager.
    sleep_n = 1'b0;
    wait_on(0, 1'b1);
    done_hk = 1'b1;
    step(1);
    done_hk = 1'b0;
    wait_on(1, 1'b1);
    chk(8'({gate_n, hold, link_a.retention_active, jt_a}), 8'h07, "frozen");
    chk(oe_a, 8'h00, "frozen outputs");
    repeat (2) data_chk(1'b1);
    sleep_n = 1'b1;
    wait_on(2, 1'b0);
    lag = 0;
    while (oe_a !== 8'hff && lag < 60)
    begin
      step(1);
      lag++;
    end
    chk(8'(lag), 8'(LAG), "output lag");
    wait_on(1, 1'b0);
    chk(8'({gate_n, hold, link_a.core_entry_permit, rst_out_n}), 8'h09, "resume");
    data_chk(1'b0);
    $display("test 2 done");
    // Request without permit in each variant.
    for (int v = 0; v < 2; v++)
    begin
      variant_b = v[0];
      drive_b(1'b0, 1'b0);
      step(STOP + 3);
      chk(8'(link_b.retention_active), 8'(enter_req(1'b0, 1'b0, v[0])), "variant");
      drive_b(1'b1, 1'b0);
      step(LAG + 3);
    end
    // Permit withdrawn while retained forces exit.
    drive_b(1'b0, 1'b1);
    step(STOP + 2);
    chk(8'(link_b.retention_active), 8'h01, "permit entry");
    chk(8'({jt_b, link_b.clocks_tied_high, link_b.pll_running}), 8'h06, "held flags");
    chk(cin_b, 8'hff, "retained input");
    drive_b(1'b0, 1'b0);
    step(1);
    chk(8'(link_b.retention_active), 8'h00, "permit exit");
    drive_b(1'b1, 1'b0);
    step(LAG + 3);
    $display("test 3 done");
    // Supply loss and return in both orders.
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        sup_io = 1'b0;
      else
        sup_core = 1'b0;
      step(1);
      chk(oe_b, 8'h00, "first supply lost");
      chk(8'(sv_b), 8'(k == 0), "state held");
      sup_io = 1'b0;
      sup_core = 1'b0;
      step(2);
      if (k == 0)
        sup_io = 1'b1;
      else
        sup_core = 1'b1;
      step(3);
      chk(oe_b, 8'h00, "one supply up");
      sup_io = 1'b1;
      sup_core = 1'b1;
      step(3);
      chk(oe_b, 8'hff, "both supplies up");
      chk(pout_b, cout_d, "pad data restored");
    end
    $display("test 4 done");
    complete_run();
  end
  // Watchdog against a hung handshake.
  initial
  begin
    #20000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
`default_nettype wire
